//--- rtl/half_select_consts.vh
// constants for the two-wire address decoder with half selection
`ifndef HALF_SELECT_CONSTS_VH
`define HALF_SELECT_CONSTS_VH
`define TYPE_ARRAY      4'hA
`define TYPE_HALF       4'h6
`define CMD_HALF_LOW    8'h6C
`define CMD_HALF_HIGH   8'h6E
`define CMD_HALF_QUERY  8'h6D
`define HALF_RESET      1'b0
`define HALF_DATA_BYTES 2'h2
`define BIT_LAST        4'h7
`define BYTE_BITS       4'h8
`define RESET_CLOCKS    4'h9
`endif

//--- rtl/eeprom_addr_decode.v
// two-wire target: device address decode, half select and half query
`timescale 1ns/1ns
`include "half_select_consts.vh"

// Summary of operation
// - bits 7..4 select array or half functions
// - bits 3..1 must match three strap inputs for array access; half codes are compared as whole bytes
// - bit 0 selects read or write
// - ack matching address, nack otherwise
// - one-bit half selection picks 256-byte half
// - 6Ch clears half, 6Eh sets half
// - ack both bytes after half select
// - 6Dh acks if lower, nacks if upper
// - send two arbitrary bytes after query
// - half selection zero after power-up
// - protocol reset clears half selection
// - receiver drives zero on ninth clock
module eeprom_addr_decode (
  // clock, reset, enable
  input  wire       mclk,
  input  wire       rst,
  input  wire       ce,
  // bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_n,
  // straps and elevated voltage detect
  input  wire       strap_input_0,
  input  wire       strap_input_1,
  input  wire       strap_input_2,
  input  wire       elevated_program_voltage,
  // array side
  input  wire [7:0] word_addr,
  output reg  [8:0] array_addr,
  output reg        array_selected,
  output reg        array_read,
  output reg        half_sel
);

  localparam ST_IDLE  = 4'b0001;
  localparam ST_ADDR  = 4'b0010;
  localparam ST_RX    = 4'b0100;
  localparam ST_TX    = 4'b1000;

  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg       scl_q;
  reg       sda_q;
  reg [3:0] state_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_reg;
  reg [3:0] idle_cnt_reg;
  reg       ack_phase_reg;
  reg       drive_low_reg;
  reg [1:0] data_cnt_reg;
  reg       query_reg;
  reg       half_cmd_reg;
  reg       ack_value_reg;

  // filtered levels: change accepted once stages two and three agree
  wire scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
  wire sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire start_c  = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_c   = scl_f & scl_q & ~sda_q & sda_f;

  wire [7:0] addr_byte = {shift_reg[6:0], sda_f};

  // count of the last data byte after a half command
  wire [1:0] last_data = `HALF_DATA_BYTES - 2'h1;

  // half select and half query codes
  function is_half_code;
    input [7:0] b;
    begin
      is_half_code = (b == `CMD_HALF_LOW) || (b == `CMD_HALF_HIGH) || (b == `CMD_HALF_QUERY);
    end
  endfunction

  // device address match function
  function addr_match;
    input [7:0] b;
    input [2:0] straps;
    input       hv;
    begin
      addr_match = 1'b0;
      if (b[7:4] == `TYPE_ARRAY && b[3:1] == straps)
        addr_match = 1'b1;
      if (is_half_code(b) && hv)
        addr_match = 1'b1;
    end
  endfunction

  wire [2:0] straps = {strap_input_2, strap_input_1, strap_input_0};

  // address byte accepted by this device
  wire addr_ok = addr_match(addr_byte, straps, elevated_program_voltage);

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low_reg;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_sync       <= 3'h7;
      sda_sync       <= 3'h7;
      scl_q          <= 1'b1;
      sda_q          <= 1'b1;
      state_reg      <= ST_IDLE;
      shift_reg      <= 8'h00;
      bit_reg        <= 4'h0;
      idle_cnt_reg   <= 4'h0;
      ack_phase_reg  <= 1'b0;
      drive_low_reg  <= 1'b0;
      data_cnt_reg   <= 2'h0;
      query_reg      <= 1'b0;
      half_cmd_reg   <= 1'b0;
      ack_value_reg  <= 1'b0;
      half_sel       <= `HALF_RESET;
      array_addr     <= 9'h000;
      array_selected <= 1'b0;
      array_read     <= 1'b0;
    end else if (ce) begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_q    <= scl_f;
      sda_q    <= sda_f;
      array_addr <= {half_sel, word_addr};
      // idle clock run is only counted while no transfer is open
      if (state_reg != ST_IDLE)
        idle_cnt_reg <= 4'h0;
      if (start_c) begin
        // start: restart the address phase
        state_reg      <= ST_ADDR;
        bit_reg        <= 4'h0;
        idle_cnt_reg   <= 4'h0;
        ack_phase_reg  <= 1'b0;
        drive_low_reg  <= 1'b0;
        array_selected <= 1'b0;
        query_reg      <= 1'b0;
        half_cmd_reg   <= 1'b0;
      end else if (stop_c) begin
        // stop: back to idle
        state_reg      <= ST_IDLE;
        idle_cnt_reg   <= 4'h0;
        drive_low_reg  <= 1'b0;
        array_selected <= 1'b0;
      end else if (state_reg == ST_IDLE) begin
        drive_low_reg <= 1'b0;
        // a run of idle clocks with data high is a protocol reset
        if (scl_rise && sda_f) begin
          if (idle_cnt_reg == `RESET_CLOCKS - 4'h1)
            half_sel <= `HALF_RESET;
          else
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end else if (scl_rise) begin
          idle_cnt_reg <= 4'h0;
        end
      end else if (scl_rise && !ack_phase_reg) begin
        // bit counter and shift register
        shift_reg <= addr_byte;
        if (state_reg == ST_ADDR && bit_reg == `BIT_LAST) begin
          // address byte complete
          if (addr_ok) begin
            if (addr_byte == `CMD_HALF_LOW)
              half_sel <= 1'b0;
            else if (addr_byte == `CMD_HALF_HIGH)
              half_sel <= 1'b1;
            half_cmd_reg   <= is_half_code(addr_byte) & ~addr_byte[0];
            query_reg      <= (addr_byte == `CMD_HALF_QUERY);
            array_selected <= (addr_byte[7:4] == `TYPE_ARRAY);
            array_read     <= addr_byte[0];
            // query answers ack for lower half, nack for upper
            ack_value_reg  <= (addr_byte == `CMD_HALF_QUERY) ? ~half_sel : 1'b1;
          end else begin
            ack_value_reg  <= 1'b0;
            state_reg      <= ST_IDLE;
          end
        end
        bit_reg <= bit_reg + 4'h1;
      end else if (scl_rise && state_reg == ST_TX) begin
        // query data ends after two bytes, a read ends on controller nack
        if (query_reg ? (data_cnt_reg == last_data) : sda_f)
          state_reg <= ST_IDLE;
      end else if (scl_fall) begin
        if (!ack_phase_reg && bit_reg == `BYTE_BITS) begin
          // eighth fall: answer bit begins, transmitter has released
          ack_phase_reg <= 1'b1;
          bit_reg       <= 4'h0;
          drive_low_reg <= (state_reg == ST_TX) ? 1'b0 :
                           (state_reg == ST_ADDR) ? ack_value_reg : 1'b1;
        end else if (ack_phase_reg) begin
          // ninth fall: answer released, next phase chosen
          ack_phase_reg <= 1'b0;
          drive_low_reg <= 1'b0;
          if (state_reg == ST_ADDR) begin
            data_cnt_reg <= 2'h0;
            if (query_reg || (array_selected && array_read))
              state_reg <= ST_TX;
            else if (half_cmd_reg || array_selected)
              state_reg <= ST_RX;
            else
              state_reg <= ST_IDLE;
          end else begin
            data_cnt_reg <= data_cnt_reg + 2'h1;
            if (half_cmd_reg && data_cnt_reg == last_data)
              state_reg <= ST_IDLE;
          end
        end else begin
          // data bits: sda stays released
          drive_low_reg <= 1'b0;
        end
      end
    end
  end

endmodule // eeprom_addr_decode

//--- test/decode_checker_assertions.sv
// assertions on the ports of the address decoder
`timescale 1ns/1ns
module decode_checker (
  input wire       mclk, rst, ce, scl_in, sda_out, sda_oe_n, elevated_program_voltage, half_sel, array_selected,
  input wire [7:0] word_addr,
  input wire [8:0] array_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_addr_compose: assert property (!$past(rst) && $past(ce) |-> array_addr == {$past(half_sel), $past(word_addr)})
    else $error("array address wrong");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !half_sel && sda_oe_n)
    else $error("reset state wrong");
  a_half_set_hv: assert property ($rose(half_sel) |-> $past(elevated_program_voltage))
    else $error("half set without voltage");
  a_ce_freeze: assert property (!ce |=> $stable(half_sel) && $stable(sda_oe_n))
    else $error("state moved while frozen");
  a_ack_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*5] ##[1:8] sda_oe_n)
    else $error("ack length wrong");
  a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("ack began with clock high");
  a_sel_ack: assert property ($rose(array_selected) |-> ##[0:12] !sda_oe_n)
    else $error("selected without ack");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data driven high");
  c_half_up: cover property ($rose(half_sel));
  c_half_down: cover property ($fell(half_sel));
  c_array_sel: cover property ($rose(array_selected));
endmodule // decode_checker
bind eeprom_addr_decode decode_checker decode_checker_inst (.mclk, .rst, .ce, .scl_in, .sda_out, .sda_oe_n,
  .elevated_program_voltage, .half_sel, .array_selected, .word_addr, .array_addr);

//--- test/bus_ctrl_model.sv
// two-wire bus controller model, clock idles high, data released to pull-up
`timescale 1ns/1ns
module bus_ctrl_model (
  input  wire  mclk,
  input  wire  sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task wt(input int n); repeat (n) @(posedge mclk); endtask
  task start; sda_low <= 1'b1; wt(4); scl <= 1'b0; wt(1); endtask
  task stop; sda_low <= 1'b1; wt(2); scl <= 1'b1; wt(4); sda_low <= 1'b0; wt(4); endtask
  task bitx(input logic b, output logic r); sda_low <= !b; wt(4); scl <= 1'b1; wt(3); r = sda; scl <= 1'b0; wt(1); endtask
  task xfer(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task dummy(input int n); repeat (n) begin scl <= 1'b0; wt(4); scl <= 1'b1; wt(4); end endtask
endmodule // bus_ctrl_model

//--- test/tb_top.sv
// self-checking bench for the address decoder
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic       mclk = 1'b0, rst = 1'b1, ce = 1'b1, hv = 1'b0, ack;
  logic [7:0] word_addr = 8'h00;
  logic [2:0] strap = 3'h6;
  logic [7:0] bad [5] = '{8'hAE, 8'hA8, 8'hA4, 8'h2C, 8'h6E};
  wire        scl, sda_low, sda_out, sda_oe_n, array_selected, array_read, half_sel;
  wire  [8:0] array_addr;
  wire        sda = !sda_low && (sda_oe_n || sda_out);
  int         err_count = 0, checks_done = 0;
  initial forever #20 mclk = ~mclk;
  eeprom_addr_decode eeprom_addr_decode_inst (.mclk, .rst, .ce, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
    .strap_input_0(strap[0]), .strap_input_1(strap[1]), .strap_input_2(strap[2]), .elevated_program_voltage(hv),
    .word_addr, .array_addr, .array_selected, .array_read, .half_sel);
  bus_ctrl_model bus_ctrl_model_inst (.mclk, .sda, .scl, .sda_low);
  task cmd(input logic [7:0] a, input int n, input logic [7:0] d, input logic e0, input logic e1);
    bus_ctrl_model_inst.start();
    bus_ctrl_model_inst.xfer(a, ack);
    `CHK(ack, e0)
    if (e0) repeat (n) begin bus_ctrl_model_inst.xfer(d, ack); `CHK(ack, e1) end
    bus_ctrl_model_inst.stop();
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    `CHK(half_sel, 1'b0)
    cmd(8'hAC, 2, 8'h3C, 1'b1, 1'b1);
    `CHK(array_read, 1'b0)
    cmd(8'hAD, 1, 8'hFF, 1'b1, 1'b0);
    `CHK(array_read, 1'b1)
    foreach (bad[i]) cmd(bad[i], 0, 8'h00, 1'b0, 1'b0);
    `CHK(half_sel, 1'b0)
    hv <= 1'b1;
    cmd(8'h6E, 2, 8'h00, 1'b1, 1'b1);
    `CHK(half_sel, 1'b1)
    cmd(8'hAE, 0, 8'h00, 1'b0, 1'b0);
    `CHK(half_sel, 1'b1)
    word_addr <= 8'h5A;
    repeat (2) @(posedge mclk);
    `CHK(array_addr, 9'h15A)
    cmd(8'h6D, 2, 8'hFF, 1'b0, 1'b0);
    `CHK(half_sel, 1'b1)
    cmd(8'h6C, 2, 8'h00, 1'b1, 1'b1);
    `CHK(half_sel, 1'b0)
    cmd(8'h6D, 2, 8'hFF, 1'b1, 1'b0);
    cmd(8'h6E, 2, 8'h00, 1'b1, 1'b1);
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    hv <= 1'b0;
    bus_ctrl_model_inst.dummy(9);
    bus_ctrl_model_inst.start();
    bus_ctrl_model_inst.stop();
    `CHK(half_sel, 1'b0)
    tally_and_finish();
  end
endmodule // tb_top
